// ---- hdl/dtc_top.sv ----
// Dual timer/counter with run/flag, mode and enable registers on AXI4-Lite.
// Assumes count and gate pins are synchronous to aclk and that the
// interrupt controller pulses the acknowledge inputs when it services a flag.
//
// Notes on behaviour
// - Timer mode counts once per machine cycle of twelve clocks.
// - Counter mode counts falling input edges, seen over two machine cycles.
// - Counting needs run bit set and gate off or gate pin high.
// - Mode 0 counts high byte plus low five bits, overflow on rollover.
// - Mode 1 is mode 0 with all sixteen bits.
// - Mode 2 counts low byte; overflow sets flag and reloads from high byte.
// - The reload never modifies the high byte.
// - Timer 1 in mode 3 holds its count as if stopped.
// - Timer 0 mode 3: low byte is 8-bit counter with timer 0 controls.
// - Timer 0 mode 3: high byte times machine cycles, run 1, flag 1.
// - Then timer 1 starts/stops via its mode 3 and raises no own flag.
// - Timer 1 overflow sets flag bit 7; software or service clears it.
// - Timer 0 overflow sets flag bit 5; software or service clears it.
// - Clearing run bit 6 halts timer 1.
// - Clearing run bit 4 halts timer 0.
// - Bit 3 holds external irq 1 edge flag, bit 2 its type.
// - Bit 1 holds external irq 0 edge flag, bit 0 its type.
// - Timer 1 request is suppressed while enable bit 3 is zero.
// - Timer 0 request is suppressed while enable bit 1 is zero.
`timescale 1ns/10ps
module dtc_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [dtc_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [dtc_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // User pins
  input wire dtc_pkg::dtc_pins_t pins,
  // Interrupt controller
  input wire dtc_pkg::dtc_irq_t irq_ack,
  output dtc_pkg::dtc_irq_t irq_req,
  // Timer 1 overflow strobe for a baud rate user
  output logic baud_tick
);
  import dtc_pkg::*;

  // ----------------------------------------
  // Register bus front end
  // ----------------------------------------
  dtc_wr_t wr;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  wire wr_hit;
  wire rd_hit;
  wire [7:0] rd_data;

  dtc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awprot(awprot),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arprot(arprot),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr(wr),
    .wr_idx(wr_idx),
    .wr_hit(wr_hit),
    .rd_idx(rd_idx),
    .rd_hit(rd_hit),
    .rd_data(rd_data)
  );

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] timer_run_and_flags_q;
  logic [7:0] timer_mode_register_q;
  logic ien_all_q, timer_one_irq_enable_q, timer_zero_irq_enable_q;
  logic [15:0] cnt_q [2];
  logic [3:0] mc_q;
  dtc_irq_t irq_q;
  logic baud_q;

  wire run_bit_one = timer_run_and_flags_q[TC_RUN1];
  wire run_bit_zero = timer_run_and_flags_q[TC_RUN0];
  wire ext_irq_type_one = timer_run_and_flags_q[TC_TYPE1];
  wire ext_irq_type_zero = timer_run_and_flags_q[TC_TYPE0];
  wire ovf_flag_one = timer_run_and_flags_q[TC_OVF1];
  wire ovf_flag_zero = timer_run_and_flags_q[TC_OVF0];
  wire ext_irq_edge_flag_one = timer_run_and_flags_q[TC_EDGE1];
  wire ext_irq_edge_flag_zero = timer_run_and_flags_q[TC_EDGE0];

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire wr_timer_run_and_flags = wr.en & (wr.idx == TIMER_RUN_AND_FLAGS_IDX);
  wire wr_timer_mode_register = wr.en & (wr.idx == TIMER_MODE_REGISTER_IDX);
  wire wr_ien = wr.en & (wr.idx == INTERRUPT_ENABLE_ZERO_IDX);
  wire cnt_idx_wr = (wr_idx == CNT_LO_IDX[0]) | (wr_idx == CNT_HI_IDX[0]) |
                    (wr_idx == CNT_LO_IDX[1]) | (wr_idx == CNT_HI_IDX[1]);
  wire cnt_idx_rd = (rd_idx == CNT_LO_IDX[0]) | (rd_idx == CNT_HI_IDX[0]) |
                    (rd_idx == CNT_LO_IDX[1]) | (rd_idx == CNT_HI_IDX[1]);
  assign wr_hit = (wr_idx == TIMER_RUN_AND_FLAGS_IDX) |
                  (wr_idx == TIMER_MODE_REGISTER_IDX) |
                  (wr_idx == INTERRUPT_ENABLE_ZERO_IDX) | cnt_idx_wr;
  assign rd_hit = (rd_idx == TIMER_RUN_AND_FLAGS_IDX) |
                  (rd_idx == TIMER_MODE_REGISTER_IDX) |
                  (rd_idx == INTERRUPT_ENABLE_ZERO_IDX) | cnt_idx_rd;

  // ----------------------------------------
  // Read selection
  // ----------------------------------------
  // Enable bits for other units are not held here and read as zero
  wire [7:0] ien_view = {ien_all_q, 3'h0, timer_one_irq_enable_q, 1'b0,
                         timer_zero_irq_enable_q, 1'b0};
  assign rd_data =
    (rd_idx == TIMER_RUN_AND_FLAGS_IDX) ? timer_run_and_flags_q :
    (rd_idx == TIMER_MODE_REGISTER_IDX) ? timer_mode_register_q :
    (rd_idx == INTERRUPT_ENABLE_ZERO_IDX) ? ien_view :
    (rd_idx == CNT_LO_IDX[0]) ? cnt_q[0][7:0] :
    (rd_idx == CNT_HI_IDX[0]) ? cnt_q[0][15:8] :
    (rd_idx == CNT_LO_IDX[1]) ? cnt_q[1][7:0] :
    (rd_idx == CNT_HI_IDX[1]) ? cnt_q[1][15:8] : 8'h00;

  // ----------------------------------------
  // Machine cycle and input edges
  // ----------------------------------------
  wire mc_tick = (mc_q == MC_LAST);
  wire [3:0] edge_pin = {pins.external_irq_input_one, pins.external_irq_input_zero,
                         pins.count_input_one, pins.count_input_zero};
  // Count inputs sample once per machine cycle; irq inputs every clock
  wire [3:0] edge_en = {1'b1, 1'b1, mc_tick, mc_tick};
  logic [3:0] edge_fall;

  for (genvar e = 0; e < 4; e++) begin : g_edge
    dtc_edge u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .smp_en(edge_en[e]),
      .pin(edge_pin[e]),
      .fall(edge_fall[e])
    );
  end

  // ----------------------------------------
  // Count step per mode
  // ----------------------------------------
  // Returns overflow and next count; the split mode steps the low byte only
  function automatic logic [16:0] cnt_step(input dtc_mode_t m, input logic [15:0] c);
    logic [12:0] n13;
    logic [16:0] r;
    n13 = 13'({c[15:8], c[4:0]} + 13'h0001);
    r = {1'b0, c};
    unique case (m)
      DTC_MODE_13B: r = {&{c[15:8], c[4:0]}, n13[12:5], c[7:5], n13[4:0]};
      DTC_MODE_16B: r = {&c, 16'(c + 16'h0001)};
      DTC_MODE_8B_RELOAD: r = (&c[7:0]) ? {1'b1, c[15:8], c[15:8]} :
                                          {1'b0, c[15:8], 8'(c[7:0] + 8'h01)};
      DTC_MODE_SPLIT: r = {&c[7:0], c[15:8], 8'(c[7:0] + 8'h01)};
    endcase
    return r;
  endfunction : cnt_step

  // ----------------------------------------
  // Per-timer counting
  // ----------------------------------------
  wire split0 = dtc_mode_t'(timer_mode_register_q[1:0]) == DTC_MODE_SPLIT;
  wire hi0_run = split0 & run_bit_one & mc_tick;
  wire hi0_ovf = hi0_run & (&cnt_q[0][15:8]);
  wire [1:0] tr = {run_bit_one, run_bit_zero};
  wire [1:0] gin = {pins.external_irq_input_one, pins.external_irq_input_zero};
  logic [1:0] ovf;
  logic [15:0] cnt_d [2];

  for (genvar i = 0; i < 2; i++) begin : g_tmr
    wire [3:0] fld = timer_mode_register_q[TM_NIB_W*i +: TM_NIB_W];
    wire dtc_mode_t md = dtc_mode_t'(fld[1:0]);
    wire ev = fld[TM_CSEL] ? edge_fall[i] : mc_tick;
    // Timer 1 in its split mode holds exactly as with the run bit clear
    wire hold = (i == 1) && (md == DTC_MODE_SPLIT);
    wire run = tr[i] & (~fld[TM_GATE] | gin[i]) & ev & ~hold;
    wire [16:0] st = cnt_step(md, cnt_q[i]);
    wire wl = wr.en & (wr.idx == CNT_LO_IDX[i]);
    wire wh = wr.en & (wr.idx == CNT_HI_IDX[i]);
    wire [7:0] hi_hw = (i == 0 && split0) ?
                       (hi0_run ? 8'(cnt_q[i][15:8] + 8'h01) : cnt_q[i][15:8]) :
                       (run ? st[15:8] : cnt_q[i][15:8]);
    // A software write to a count byte wins over the step in that cycle
    assign cnt_d[i][7:0] = wl ? wr.data : (run ? st[7:0] : cnt_q[i][7:0]);
    assign cnt_d[i][15:8] = wh ? wr.data : hi_hw;
    assign ovf[i] = run & st[16];
  end

  // ----------------------------------------
  // Flag next values
  // ----------------------------------------
  // Hardware set wins over a software or service clear in the same cycle
  wire set1 = (ovf[1] & ~split0) | hi0_ovf;
  wire set0 = ovf[0];
  wire tf1_d = set1 | (wr_timer_run_and_flags ? wr.data[TC_OVF1] : (ovf_flag_one & ~irq_ack.tmr1));
  wire tf0_d = set0 | (wr_timer_run_and_flags ? wr.data[TC_OVF0] : (ovf_flag_zero & ~irq_ack.tmr0));
  wire tr1_d = wr_timer_run_and_flags ? wr.data[TC_RUN1] : run_bit_one;
  wire tr0_d = wr_timer_run_and_flags ? wr.data[TC_RUN0] : run_bit_zero;
  wire it1_d = wr_timer_run_and_flags ? wr.data[TC_TYPE1] : ext_irq_type_one;
  wire it0_d = wr_timer_run_and_flags ? wr.data[TC_TYPE0] : ext_irq_type_zero;
  // Level type: the flag follows the inverted pin and cannot be cleared
  wire ie1_hold = wr_timer_run_and_flags ? wr.data[TC_EDGE1] : (ext_irq_edge_flag_one & ~irq_ack.ext1);
  wire ie0_hold = wr_timer_run_and_flags ? wr.data[TC_EDGE0] : (ext_irq_edge_flag_zero & ~irq_ack.ext0);
  wire ie1_d = ext_irq_type_one ? (edge_fall[3] | ie1_hold) :
                                  ~pins.external_irq_input_one;
  wire ie0_d = ext_irq_type_zero ? (edge_fall[2] | ie0_hold) :
                                   ~pins.external_irq_input_zero;
  wire [7:0] timer_run_and_flags_d = {tf1_d, tr1_d, tf0_d, tr0_d, ie1_d, it1_d, ie0_d, it0_d};

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_run_and_flags_q <= TIMER_RUN_AND_FLAGS_RST;
      timer_mode_register_q <= TIMER_MODE_REGISTER_RST;
      ien_all_q <= IEN_RST[IE_ALL];
      timer_one_irq_enable_q <= IEN_RST[IE_TMR1];
      timer_zero_irq_enable_q <= IEN_RST[IE_TMR0];
      cnt_q[0] <= CNT_RST;
      cnt_q[1] <= CNT_RST;
      mc_q <= 4'h0;
    end else begin
      timer_run_and_flags_q <= timer_run_and_flags_d;
      cnt_q[0] <= cnt_d[0];
      cnt_q[1] <= cnt_d[1];
      mc_q <= mc_tick ? 4'h0 : 4'(mc_q + 4'h1);
      if (wr_timer_mode_register) begin
        timer_mode_register_q <= wr.data;
      end
      if (wr_ien) begin
        ien_all_q <= wr.data[IE_ALL];
        timer_one_irq_enable_q <= wr.data[IE_TMR1];
        timer_zero_irq_enable_q <= wr.data[IE_TMR0];
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Requests trail their flags by one clock so every output is a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= '0;
      baud_q <= 1'b0;
    end else begin
      irq_q.tmr1 <= ovf_flag_one & timer_one_irq_enable_q & ien_all_q;
      irq_q.tmr0 <= ovf_flag_zero & timer_zero_irq_enable_q & ien_all_q;
      irq_q.ext1 <= ext_irq_edge_flag_one & ien_all_q;
      irq_q.ext0 <= ext_irq_edge_flag_zero & ien_all_q;
      baud_q <= ovf[1];
    end
  end

  assign irq_req = irq_q;
  assign baud_tick = baud_q;

endmodule : dtc_top

// ---- inc/dtc_pkg.sv ----
// Constants, mode codes and signal carriers of the dual timer/counter block.
// Assumes the register bus addresses each register by index times four.
package dtc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  // One machine cycle is twelve clock periods (600 ns at 20 MHz)
  localparam int unsigned MC_CLKS = 12;
  localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register indices; byte address is index times four
  localparam logic [7:0] TIMER_RUN_AND_FLAGS_IDX = 8'h88;
  localparam logic [7:0] TIMER_MODE_REGISTER_IDX = 8'h89;
  localparam logic [7:0] INTERRUPT_ENABLE_ZERO_IDX = 8'ha8;
  localparam logic [7:0] CNT_LO_IDX [2] = '{8'hc0, 8'hc2};
  localparam logic [7:0] CNT_HI_IDX [2] = '{8'hc1, 8'hc3};

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned TC_OVF1 = 7;
  localparam int unsigned TC_RUN1 = 6;
  localparam int unsigned TC_OVF0 = 5;
  localparam int unsigned TC_RUN0 = 4;
  localparam int unsigned TC_EDGE1 = 3;
  localparam int unsigned TC_TYPE1 = 2;
  localparam int unsigned TC_EDGE0 = 1;
  localparam int unsigned TC_TYPE0 = 0;
  localparam int unsigned TM_NIB_W = 4;
  localparam int unsigned TM_GATE = 3;
  localparam int unsigned TM_CSEL = 2;
  localparam int unsigned IE_ALL = 7;
  localparam int unsigned IE_TMR1 = 3;
  localparam int unsigned IE_TMR0 = 1;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] TIMER_RUN_AND_FLAGS_RST = 8'h00;
  localparam logic [7:0] TIMER_MODE_REGISTER_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    DTC_MODE_13B = 2'h0,
    DTC_MODE_16B = 2'h1,
    DTC_MODE_8B_RELOAD = 2'h2,
    DTC_MODE_SPLIT = 2'h3
  } dtc_mode_t;

  typedef struct packed {
    logic external_irq_input_one;
    logic external_irq_input_zero;
    logic count_input_one;
    logic count_input_zero;
  } dtc_pins_t;

  typedef struct packed {
    logic tmr1;
    logic tmr0;
    logic ext1;
    logic ext0;
  } dtc_irq_t;

  typedef struct packed {
    logic en;
    logic [7:0] idx;
    logic [7:0] data;
  } dtc_wr_t;

endpackage : dtc_pkg

// ---- hdl/dtc_edge.sv ----
// Falling-edge detector sampled on an enable strobe.
// Assumes the pin is synchronous to aclk.
`timescale 1ns/10ps
module dtc_edge (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sampling
  input wire logic smp_en,
  input wire logic pin,
  output logic fall
);

  logic last_q;
  logic fall_q;

  // Low reset value: a pin held low through reset gives no false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      fall_q <= smp_en & last_q & ~pin;
      if (smp_en) begin
        last_q <= pin;
      end
    end
  end

  assign fall = fall_q;

endmodule : dtc_edge

// ---- hdl/dtc_axil.sv ----
// AXI4-Lite slave front end that turns bus transfers into byte writes/reads.
// Assumes the owner decodes the index combinationally and returns hit/data.
`timescale 1ns/10ps
module dtc_axil (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [dtc_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [dtc_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output dtc_pkg::dtc_wr_t wr,
  output logic [7:0] wr_idx,
  input wire logic wr_hit,
  output logic [7:0] rd_idx,
  input wire logic rd_hit,
  input wire logic [7:0] rd_data
);
  import dtc_pkg::*;

  logic aw_have_q, w_have_q, ar_have_q;
  logic aw_ok_q, ar_ok_q;
  logic [7:0] aw_idx_q, ar_idx_q, wd_q;
  logic ws_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] rdata_q;
  dtc_wr_t wr_q;

  wire aw_take = awvalid & awready_q;
  wire w_take = wvalid & wready_q;
  wire ar_take = arvalid & arready_q;
  wire w_fire = aw_have_q & w_have_q & ~bvalid_q;
  wire w_good = aw_ok_q & wr_hit;
  wire r_good = ar_ok_q & rd_hit;
  // Bits above the mapped window make the access unmapped
  wire aw_ok = awaddr[ADDR_W-1:IDX_LSB+IDX_W] == '0;
  wire ar_ok = araddr[ADDR_W-1:IDX_LSB+IDX_W] == '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      ar_have_q <= 1'b0;
      aw_ok_q <= 1'b0;
      ar_ok_q <= 1'b0;
      aw_idx_q <= 8'h00;
      ar_idx_q <= 8'h00;
      wd_q <= 8'h00;
      ws_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= 8'h00;
      wr_q <= '0;
    end else begin
      wr_q.en <= 1'b0;
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        aw_ok_q <= aw_ok;
        aw_idx_q <= awaddr[IDX_LSB +: IDX_W];
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        wd_q <= wdata[7:0];
        ws_q <= wstrb[0];
      end
      if (w_fire) begin
        // A write without lane 0 stores nothing but still answers
        wr_q.en <= w_good & ws_q;
        wr_q.idx <= aw_idx_q;
        wr_q.data <= wd_q;
        bresp_q <= w_good ? RESP_OKAY : RESP_SLVERR;
        bvalid_q <= 1'b1;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
      if (ar_take) begin
        ar_have_q <= 1'b1;
        arready_q <= 1'b0;
        ar_ok_q <= ar_ok;
        ar_idx_q <= araddr[IDX_LSB +: IDX_W];
      end
      if (ar_have_q) begin
        ar_have_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= r_good ? rd_data : 8'h00;
        rresp_q <= r_good ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = {24'h00_0000, rdata_q};
  assign wr = wr_q;
  assign wr_idx = aw_idx_q;
  assign rd_idx = ar_idx_q;

endmodule : dtc_axil

// ---- testbench/dtc_checker.sv ----
// Bus and timing checks for the dual timer/counter top.
// Assumes it is bound to dtc_top and sees only its ports.
`timescale 1ns/10ps
module dtc_checker import dtc_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // Timer outputs
  input wire dtc_pkg::dtc_irq_t irq_req,
  input wire logic baud_tick
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken;
    arvalid && arready;
  endsequence
  wr_answer_a: assert property (wr_taken |=> !bvalid ##1 bvalid) else $error("late bvalid");
  rd_answer_a: assert property (rd_taken |=> !rvalid ##1 rvalid) else $error("late rvalid");
  wr_lock_a: assert property (bvalid |-> !awready && !wready) else $error("ready in write");
  b_release_a: assert property (bvalid && bready |=> !bvalid && awready) else $error("b stuck");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data moved");
  rdata_hi_a: assert property (rvalid |-> rdata[31:8] == 24'h00_0000) else $error("rdata hi");
  baud_gap_a: assert property (baud_tick |=> !baud_tick [*8]) else $error("tick gap");
  reset_quiet_a: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !baud_tick
    && irq_req == 4'h0) else $error("not quiet after reset");
endmodule : dtc_checker

// ---- testbench/dtc_pin_model.sv ----
// Pin and interrupt controller model on the far side of the timers.
// Assumes go is a one-clock strobe that starts a burst of three edges.
`timescale 1ns/10ps
module dtc_pin_model import dtc_pkg::*; (
  // Clock
  input wire logic aclk,
  // Controls
  input wire logic go,
  input wire logic gate,
  input wire logic ack_en,
  // Device side
  input wire dtc_pkg::dtc_irq_t irq_req,
  output dtc_pkg::dtc_pins_t pins,
  output dtc_pkg::dtc_irq_t irq_ack
);
  int unsigned ph;
  initial begin
    ph = 0;
    pins = 4'hf;
    irq_ack = 4'h0;
  end
  // Each level is held a full machine cycle so the sampler sees it
  always @(posedge aclk) begin
    irq_ack <= ack_en ? (irq_req & ~irq_ack) : 4'h0;
    pins.external_irq_input_zero <= gate;
    if (go || ph != 0) begin
      ph <= (ph == 6 * MC_CLKS) ? 0 : ph + 1;
    end
    pins.count_input_zero <= (ph == 0) || ((ph / MC_CLKS) % 2 == 0);
  end
endmodule : dtc_pin_model

// ---- testbench/tb.sv ----
// Self-checking bench for the dual timer/counter block.
// Assumes the pin model answers for pins and interrupt service.
`timescale 1ns/10ps
module tb;
  import dtc_pkg::*;
  localparam logic [7:0] RF = TIMER_RUN_AND_FLAGS_IDX;
  localparam logic [7:0] MD = TIMER_MODE_REGISTER_IDX;
  localparam logic [7:0] IE = INTERRUPT_ENABLE_ZERO_IDX;
  localparam logic [7:0] L0 = CNT_LO_IDX[0];
  localparam logic [7:0] H0 = CNT_HI_IDX[0];
  localparam logic [7:0] L1 = CNT_LO_IDX[1];
  localparam logic [7:0] H1 = CNT_HI_IDX[1];
  localparam logic [7:0] RI [7] = '{RF, MD, IE, L0, H0, L1, H1};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, gate, ack_en;
  logic awready, wready, bvalid, arready, rvalid, baud_tick;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, last_resp;
  logic [7:0] v, w;
  dtc_pins_t pins;
  dtc_irq_t irq_ack, irq_req;
  int error_cnt, check_count;
  int baud_n = 0;
  // Counts timer 1 overflow strobes for the split-mode scenario
  always @(posedge aclk) begin
    if (baud_tick) baud_n++;
  end
  dtc_top DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pins, .irq_ack, .irq_req,
    .baud_tick);
  dtc_pin_model u_pins (.aclk, .go, .gate, .ack_en, .irq_req, .pins, .irq_ack);
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    awaddr <= ADDR_W'({i, 2'b00});
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  // Ready is raised late so the held answer is seen too
  task automatic rd(input logic [7:0] i, output logic [7:0] d);
    araddr <= ADDR_W'({i, 2'b00});
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    d = rdata[7:0];
    last_resp = rresp;
  endtask : rd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    rd(i, v);
    chk(v, e);
  endtask : rc
  task automatic mcs(input int n);
    repeat (n * MC_CLKS) @(posedge aclk);
  endtask : mcs
  task automatic burst;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    mcs(9);
  endtask : burst
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int k = 0; k < 7; k++) rc(RI[k], 8'h00);
    mcs(3);
    rc(L0, 8'h00);
    rd(8'h10, v);
    chk({6'h00, last_resp}, 8'h02);
  endtask : t_reset
  task automatic t_mode1;
    wr(IE, 8'h80);
    wr(MD, 8'h01);
    wr(H0, 8'hff);
    wr(L0, 8'hfe);
    wr(RF, 8'h10);
    mcs(2);
    rc(RF, 8'h30);
    chk({7'h00, irq_req.tmr0}, 8'h00);
    wr(RF, 8'h20);
    rd(L0, w);
    mcs(2);
    rc(L0, w);
    wr(IE, 8'h82);
    mcs(1);
    chk({7'h00, irq_req.tmr0}, 8'h01);
    ack_en <= 1'b1;
    mcs(1);
    ack_en <= 1'b0;
    rc(RF, 8'h00);
  endtask : t_mode1
  task automatic t_mode02(input logic [7:0] m, input logic [7:0] h);
    wr(MD, m);
    wr(H0, h);
    wr(L0, 8'hfe);
    wr(RF, 8'h10);
    mcs(2);
    rc(RF, 8'h30);
    wr(RF, 8'h00);
    rc(H0, (m == 8'h02) ? h : 8'h00);
    rd(L0, v);
    chk(v & ((m == 8'h02) ? 8'hfe : 8'h1e), (m == 8'h02) ? h : 8'h00);
  endtask : t_mode02
  task automatic t_counter;
    wr(MD, 8'h05);
    wr(L0, 8'h00);
    wr(H0, 8'h00);
    wr(RF, 8'h10);
    burst();
    rc(L0, 8'h03);
    gate <= 1'b0;
    wr(MD, 8'h0d);
    burst();
    rc(L0, 8'h03);
    rc(RF, 8'h12);
    gate <= 1'b1;
    burst();
    rc(L0, 8'h06);
  endtask : t_counter
  // Low byte of timer 0 runs on its own controls while the high byte takes timer 1's
  task automatic t_split;
    wr(RF, 8'h00);
    wr(MD, 8'h03);
    wr(H0, 8'h00);
    wr(L0, 8'hfe);
    wr(H1, 8'hff);
    wr(L1, 8'h1e);
    wr(RF, 8'h50);
    mcs(2);
    rc(RF, 8'h70);
    chk(8'(baud_n), 8'h01);
    wr(H0, 8'hfe);
    mcs(2);
    rc(RF, 8'hf0);
    chk({6'h00, irq_req.tmr1, irq_req.tmr0}, 8'h01);
    wr(IE, 8'h8a);
    mcs(1);
    chk({7'h00, irq_req.tmr1}, 8'h01);
    rd(L0, v);
    chk(v & 8'hf0, 8'h00);
    wr(MD, 8'h33);
    rd(L1, w);
    mcs(2);
    rc(L1, w);
    wr(RF, 8'h05);
    rc(RF, 8'h05);
  endtask : t_split
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go, ack_en} = 8'h00;
    gate = 1'b1;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_mode1();
    t_mode02(8'h00, 8'hff);
    t_mode02(8'h02, 8'hf0);
    t_counter();
    t_split();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb
bind dtc_top dtc_checker u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .irq_req, .baud_tick);
